// [core/bir_pkg.sv]
// constants shared by the board interrupt routing block
package bir_pkg;
  localparam int BIR_PROC_IRQS = 4; // processor request lines
  localparam int BIR_JUMPERS = 4; // divisor jumper count
  localparam int BIR_EXT_IRQS = 16; // width of the extra-interrupt capture chain
  localparam int BIR_ISA_IRQS = 16; // cascaded legacy controller inputs
  localparam int BIR_PRI_ERR = 20; // fixed level of request line zero
  localparam int BIR_PRI_DEV = 21; // fixed level of request line one
  localparam int BIR_PRI_IPI = 22; // fixed level of request line two
  localparam int BIR_PRI_RSV = 23; // fixed level of request line three
  localparam int BIR_PRI_MCHK = 31; // fixed level of machine check input
  localparam int BIR_IDX_ERR = 0; // request line positions
  localparam int BIR_IDX_DEV = 1;
  localparam int BIR_IDX_IPI = 2;
  localparam int BIR_IDX_RSV = 3;
  localparam int BIR_CASCADE_IRQ = 2; // slave controller feeds this master input
  localparam int BIR_RESERVED_IRQ = 8; // reserved isa input, forced off
  localparam logic [15:0] BIR_CHAIN_RST = 16'h0000; // chain value after reset
  localparam logic [3:0] BIR_IRQ_RST = 4'h0; // request lines after reset
endpackage

// [core/bir_chain.sv]
// parallel-load serial-out capture chain for extra interrupts
`timescale 1ns/10ps
module bir_chain
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic shift_en,
  input wire logic [bir_pkg::BIR_EXT_IRQS-1:0] par_in,
  output logic ser_out
);
  import bir_pkg::*;

  logic [BIR_EXT_IRQS-1:0] chain; // captured interrupt bits

  // load wins over shift so a capture is never torn by a scan
  always_ff @(posedge clk)
  begin
    if (rst)
      chain <= BIR_CHAIN_RST;
    else if (load)
      chain <= par_in;
    else if (shift_en)
      chain <= {chain[BIR_EXT_IRQS-2:0], 1'b0};
  end

  // serial output is the far end of the chain, straight from a flop
  assign ser_out = chain[BIR_EXT_IRQS-1];

  AST_LOAD_CAPT: assert property (@(posedge clk) disable iff (rst)
    load |=> ser_out == $past(par_in[BIR_EXT_IRQS-1]))
    else $error("chain load did not capture parallel word");
  AST_SHIFT_ONE: assert property (@(posedge clk) disable iff (rst)
    !load && shift_en |=> ser_out == $past(chain[BIR_EXT_IRQS-2]))
    else $error("chain did not shift by one place");
  AST_HOLD_NOSHIFT: assert property (@(posedge clk) disable iff (rst)
    !load && !shift_en |=> $stable(chain))
    else $error("chain changed without load or shift");
  COV_LOAD_SHIFT: cover property (@(posedge clk) disable iff (rst)
    load ##1 (shift_en && !load) [*3]);
endmodule

// [core/bir_top.sv]
// board interrupt routing: processor request lines, machine check, chain
`timescale 1ns/10ps
module bir_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [bir_pkg::BIR_JUMPERS-1:0] divisor_jumper_block,
  input wire logic ecc_corrected,
  input wire logic sparse_rsvd,
  input wire logic [3:0] pci_irq,
  input wire logic isa_timer,
  input wire logic isa_keyboard,
  input wire logic isa_com2,
  input wire logic isa_com1,
  input wire logic isa_floppy,
  input wire logic isa_parallel,
  input wire logic isa_mouse,
  input wire logic isa_ide_pri,
  input wire logic isa_ide_sec,
  input wire logic [5:0] isa_avail,
  input wire logic ipi_req,
  input wire logic timer_req,
  input wire logic bridge_nmi,
  input wire logic core_err,
  input wire logic intack,
  input wire logic [bir_pkg::BIR_EXT_IRQS-1:0] ext_irq,
  input wire logic chain_load,
  input wire logic chain_shift,
  output logic [bir_pkg::BIR_PROC_IRQS-1:0] proc_irq,
  output logic mchk_irq,
  output logic pwr_fail_irq,
  output logic hlt_irq,
  output logic [bir_pkg::BIR_ISA_IRQS-1:0] isa_pending,
  output logic serial_irq_chain_out
);
  import bir_pkg::*;

  // pin synchronisers: first stage feeds only the second stage
  // avail bit 5 carries the reserved isa input, which is never forwarded,
  // so it is not taken in at all; jumpers have a pair of their own below
  localparam int SYW = 27 + BIR_EXT_IRQS;
  logic [SYW-1:0] sy1; // first stage
  logic [SYW-1:0] sy2; // second stage, the only one logic reads
  logic [SYW-1:0] raw; // packed pin inputs, ecc in bit zero
  assign raw = {ext_irq, chain_load, chain_shift, intack, core_err, bridge_nmi,
    timer_req, ipi_req, isa_avail[4:0], isa_ide_sec, isa_ide_pri, isa_mouse,
    isa_parallel, isa_floppy, isa_com1, isa_com2, isa_keyboard, isa_timer,
    pci_irq, sparse_rsvd, ecc_corrected};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sy1 <= '0;
      sy2 <= '0;
    end
    else
    begin
      sy1 <= raw;
      sy2 <= sy1;
    end
  end

  // jumper synchroniser: static straps, deliberately left out of reset so
  // that the divisor code is already settled while rst is still held
  logic [BIR_JUMPERS-1:0] jmp_sy1; // jumper first stage
  logic [BIR_JUMPERS-1:0] jmp_sy2; // jumper second stage
  always_ff @(posedge clk)
  begin
    jmp_sy1 <= divisor_jumper_block;
    jmp_sy2 <= jmp_sy1;
  end
  // limitation: the straps show two clocks after power-up or a jumper move,
  // so reset must be held longer than that before the code is trusted

  // named views of synchronised inputs
  logic [3:0] s_jmp; // divisor code shown on the lines during reset
  logic s_ecc, s_sparse, s_ipi, s_tmr, s_nmi, s_cerr, s_ack, s_shift, s_load;
  logic [3:0] s_pci;
  logic [8:0] s_isa_dev; // fixed-use isa sources, timer in bit zero
  logic [4:0] s_isa_avail; // spare isa sources in ascending input order
  logic [BIR_EXT_IRQS-1:0] s_ext;
  assign s_jmp = jmp_sy2;
  assign s_ecc = sy2[0];
  assign s_sparse = sy2[1];
  assign s_pci = sy2[5:2];
  assign s_isa_dev = sy2[14:6];
  assign s_isa_avail = sy2[19:15];
  assign s_ipi = sy2[20];
  assign s_tmr = sy2[21];
  assign s_nmi = sy2[22];
  assign s_cerr = sy2[23];
  assign s_ack = sy2[24];
  assign s_shift = sy2[25];
  assign s_load = sy2[26];
  assign s_ext = sy2[SYW-1:27];

  // isa map: timer, kbd, cascade, com2, com1, avail, floppy, lpt / slave side
  logic [BIR_ISA_IRQS-1:0] isa_map;
  logic slave_any; // slave controller request folded onto cascade input
  always_comb
  begin
    isa_map = '0;
    isa_map[0] = s_isa_dev[0]; // internal timer
    isa_map[1] = s_isa_dev[1]; // keyboard
    isa_map[3] = s_isa_dev[2]; // serial port two
    isa_map[4] = s_isa_dev[3]; // serial port one
    isa_map[6] = s_isa_dev[4]; // diskette
    isa_map[7] = s_isa_dev[5]; // parallel port
    isa_map[12] = s_isa_dev[6]; // mouse
    isa_map[14] = s_isa_dev[7]; // ide
    isa_map[15] = s_isa_dev[8]; // ide
    // available inputs, free for expansion cards
    isa_map[5] = s_isa_avail[0];
    isa_map[9] = s_isa_avail[1];
    isa_map[10] = s_isa_avail[2];
    isa_map[11] = s_isa_avail[3];
    isa_map[13] = s_isa_avail[4];
    isa_map[BIR_RESERVED_IRQ] = 1'b0; // reserved input never raised
    slave_any = |isa_map[15:8]; // second controller cascades
    isa_map[BIR_CASCADE_IRQ] = slave_any;
  end

  // pending view held until the processor acknowledges; set wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
      isa_pending <= '0;
    else
      isa_pending <= isa_map | (s_ack ? '0 : isa_pending);
  end

  // routing to fixed-level request lines; levels cannot be reprogrammed
  logic [3:0] next_irq;
  always_comb
  begin
    next_irq = BIR_IRQ_RST;
    next_irq[BIR_IDX_ERR] = s_ecc | s_sparse;
    next_irq[BIR_IDX_DEV] = (|s_pci) | (|isa_pending) | serial_irq_chain_out;
    next_irq[BIR_IDX_IPI] = s_ipi | s_tmr;
    next_irq[BIR_IDX_RSV] = 1'b0;
  end

  // during reset the lines show the synchronised jumper code; the routing
  // flop is held clear meanwhile, so the first cycle after reset shows no
  // stale request from before the reset
  logic [3:0] irq_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_q <= BIR_IRQ_RST;
    else
      irq_q <= next_irq;
  end
  assign proc_irq = rst ? s_jmp : irq_q;

  // machine check from bridge nmi and core errors
  always_ff @(posedge clk)
  begin
    if (rst)
      mchk_irq <= 1'b0;
    else
      mchk_irq <= s_nmi | s_cerr;
  end
  assign pwr_fail_irq = 1'b0;
  assign hlt_irq = 1'b0;

  // capture chain for interrupts beyond the legacy controllers
  bir_chain u_chain
  (
    .clk(clk),
    .rst(rst),
    .load(s_load),
    .shift_en(s_shift),
    .par_in(s_ext),
    .ser_out(serial_irq_chain_out)
  );

  // in reset the lines trail the straps by the two synchroniser clocks;
  // the first two clocks after power-up carry no settled code yet
  AST_RESET_JUMPERS: assert property (@(posedge clk)
    rst && $past(rst, 2) |-> proc_irq == $past(divisor_jumper_block, 2))
    else $error("request lines not showing jumpers in reset");
  AST_ERR_LINE: assert property (@(posedge clk) disable iff (rst)
    (s_ecc | s_sparse) |=> proc_irq[BIR_IDX_ERR])
    else $error("line zero missed error");
  AST_DEV_LINE: assert property (@(posedge clk) disable iff (rst)
    (|s_pci) ##1 !rst |-> proc_irq[BIR_IDX_DEV])
    else $error("line one missed pci interrupt");
  AST_IPI_LINE: assert property (@(posedge clk) disable iff (rst)
    proc_irq[BIR_IDX_IPI] == $past(s_ipi | s_tmr))
    else $error("line two wrong");
  AST_MCHK: assert property (@(posedge clk) disable iff (rst)
    mchk_irq == $past(s_nmi | s_cerr))
    else $error("machine check wrong");
  AST_RSV_OFF: assert property (@(posedge clk) disable iff (rst)
    !proc_irq[BIR_IDX_RSV] && !pwr_fail_irq && !hlt_irq)
    else $error("reserved input raised");
  AST_CASCADE: assert property (@(posedge clk) disable iff (rst)
    (|isa_map[15:8]) |=> isa_pending[BIR_CASCADE_IRQ])
    else $error("cascade input not raised");
  // watched on the pending output, where a stray reserved request would show
  AST_IRQ8_OFF: assert property (@(posedge clk) disable iff (rst)
    !isa_pending[BIR_RESERVED_IRQ])
    else $error("reserved isa input raised");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    s_ack && isa_map[1] |=> isa_pending[1])
    else $error("acknowledge lost a new request");
  COV_RESET_EXIT: cover property (@(posedge clk) rst ##1 !rst);
  COV_DEV_IRQ: cover property (@(posedge clk) disable iff (rst) proc_irq[BIR_IDX_DEV]);
  COV_MCHK: cover property (@(posedge clk) disable iff (rst) mchk_irq);
  COV_ACK: cover property (@(posedge clk) disable iff (rst) s_ack ##1 !(|isa_pending));
endmodule

// [core/bir_unused.sv]
// holds no logic: the block lives in bir_top and bir_chain

// [tb/bir_host_model.sv]
// host processor model: reads request levels, issues acknowledge
`timescale 1ns/10ps
module bir_host_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [bir_pkg::BIR_PROC_IRQS-1:0] proc_irq,
  input wire logic mchk_irq,
  input wire logic ack_req,
  output logic intack,
  output logic [4:0] priority_level
);
  import bir_pkg::*;
  // acknowledge repeats ack_req one clock later, as many clocks wide as ack_req is held
  always_ff @(posedge clk)
  begin
    if (rst)
      intack <= 1'b0;
    else
      intack <= ack_req;
  end
  // highest fixed level pending; zero when idle
  always_comb
  begin
    if (mchk_irq)
      priority_level = 5'(BIR_PRI_MCHK);
    else if (proc_irq[BIR_IDX_RSV])
      priority_level = 5'(BIR_PRI_RSV);
    else if (proc_irq[BIR_IDX_IPI])
      priority_level = 5'(BIR_PRI_IPI);
    else if (proc_irq[BIR_IDX_DEV])
      priority_level = 5'(BIR_PRI_DEV);
    else if (proc_irq[BIR_IDX_ERR])
      priority_level = 5'(BIR_PRI_ERR);
    else
      priority_level = 5'h00;
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the board interrupt routing block
`timescale 1ns/10ps
module tb_top;
  import bir_pkg::*;
  logic clk, rst, ack_req, intack, chain_load, chain_shift, mchk_irq;
  logic pwr_fail_irq, hlt_irq, serial_irq_chain_out;
  logic [3:0] divisor_jumper_block, proc_irq;
  logic [9:0] src; // ecc, sparse, pci x4, ipi, timer, nmi, core error
  logic [15:0] isa_in, ext_irq, isa_pending, exp;
  logic [4:0] priority_level;
  int err_total, checks;
  bir_top u_dut (.clk, .rst, .divisor_jumper_block, .ecc_corrected(src[0]),
    .sparse_rsvd(src[1]), .pci_irq(src[5:2]), .isa_timer(isa_in[0]),
    .isa_keyboard(isa_in[1]), .isa_com2(isa_in[3]), .isa_com1(isa_in[4]),
    .isa_floppy(isa_in[6]), .isa_parallel(isa_in[7]), .isa_mouse(isa_in[12]),
    .isa_ide_pri(isa_in[14]), .isa_ide_sec(isa_in[15]),
    .isa_avail({isa_in[8], isa_in[13], isa_in[11:9], isa_in[5]}),
    .ipi_req(src[6]), .timer_req(src[7]), .bridge_nmi(src[8]), .core_err(src[9]),
    .intack, .ext_irq, .chain_load, .chain_shift, .proc_irq, .mchk_irq,
    .pwr_fail_irq, .hlt_irq, .isa_pending, .serial_irq_chain_out);
  bir_host_model u_host (.clk, .rst, .proc_irq, .mchk_irq, .ack_req, .intack,
    .priority_level);
  // free-running 8 ns clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // single compare for all vector results
  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string m);
    checks++;
    if (got !== want)
    begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, want);
    end
  endtask
  // jumpers show on request lines only while reset is held
  // reset stays high for ten clocks in all
  task automatic t_reset();
    wait_clk(5);
    chk(16'(proc_irq), 16'hA, "jumper A");
    divisor_jumper_block <= 4'h5;
    wait_clk(4);
    chk(16'(proc_irq), 16'h5, "jumper 5");
    chk({pwr_fail_irq, hlt_irq, mchk_irq}, 16'h0, "reset idle");
    rst <= 1'b0;
    wait_clk(4);
    chk(16'(proc_irq), 16'h0, "after reset");
  endtask
  // every source alone onto its request line and level
  task automatic t_lines();
    for (int i = 0; i < 10; i++)
    begin
      src <= 10'h1 << i;
      wait_clk(4);
      exp = (i < 2) ? 16'h01 : (i < 6) ? 16'h02 : (i < 8) ? 16'h04 : 16'h10;
      chk({mchk_irq, proc_irq}, exp, "line");
      exp = (i < 2) ? 16'(BIR_PRI_ERR) : (i < 6) ? 16'(BIR_PRI_DEV) :
        (i < 8) ? 16'(BIR_PRI_IPI) : 16'(BIR_PRI_MCHK);
      chk(16'(priority_level), exp, "level");
      chk({pwr_fail_irq, hlt_irq}, 16'h0, "reserved");
      src <= 10'h0;
      wait_clk(4);
      chk({mchk_irq, proc_irq}, 16'h0, "idle");
    end
  endtask
  // isa map, cascade, stickiness and acknowledge clear
  task automatic t_isa();
    for (int n = 0; n < 16; n++)
    begin
      if (n != 2)
      begin
        isa_in <= 16'h1 << n;
        wait_clk(4);
        isa_in <= 16'h0;
        wait_clk(4);
        exp = (n == 8) ? 16'h0 : ((16'h1 << n) | ((n > 8) ? 16'h4 : 16'h0));
        chk(isa_pending, exp, "isa sticky");
        chk(16'(proc_irq[1]), 16'(n != 8), "dev line");
        ack_req <= 1'b1;
        wait_clk(1);
        ack_req <= 1'b0;
        wait_clk(5);
        chk(isa_pending, 16'h0, "ack clear");
      end
    end
  endtask
  // acknowledge while a request still stands: the request must survive it
  task automatic t_ack_race();
    isa_in <= 16'h0002;
    wait_clk(4);
    ack_req <= 1'b1;
    wait_clk(1);
    ack_req <= 1'b0;
    wait_clk(5);
    chk(isa_pending, 16'h0002, "set wins");
    chk(16'(proc_irq[1]), 16'h1, "dev held");
    isa_in <= 16'h0000;
    wait_clk(4);
    ack_req <= 1'b1;
    wait_clk(1);
    ack_req <= 1'b0;
    wait_clk(5);
    chk(isa_pending, 16'h0000, "late clear");
  endtask
  // load held blocks shifting, then single shifts move msb first
  task automatic t_chain();
    ext_irq <= 16'hA5C3;
    chain_load <= 1'b1;
    chain_shift <= 1'b1;
    wait_clk(6);
    chk(16'(serial_irq_chain_out), 16'h1, "load msb");
    chain_load <= 1'b0;
    chain_shift <= 1'b0;
    wait_clk(4);
    for (int k = 14; k >= -1; k--)
    begin
      chain_shift <= 1'b1;
      wait_clk(1);
      chain_shift <= 1'b0;
      wait_clk(4);
      exp = (k < 0) ? 16'h0 : 16'(ext_irq[k]);
      chk(16'(serial_irq_chain_out), exp, "shift bit");
    end
  endtask
  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    {rst, ack_req, chain_load, chain_shift} = 4'h8;
    {src, isa_in, ext_irq} = '0;
    divisor_jumper_block = 4'hA;
    err_total = 0;
    checks = 0;
    @(posedge clk);
    t_reset();
    t_lines();
    t_isa();
    t_ack_race();
    t_chain();
    stop_test();
  end
  // watchdog, far beyond the roughly 414 cycles the tests need
  initial
  begin
    #40000;
    err_total++;
    stop_test();
  end
endmodule
